// [core/oame_params.svh]
// Opcode encodings, field positions and reset values for the exec datapath
`ifndef OAME_PARAMS_SVH
`define OAME_PARAMS_SVH

// Opcode field positions
`define OAME_OPC4_HI   11
`define OAME_OPC4_LO   8
`define OAME_OPC6_LO   6
`define OAME_DEST_BIT  5
`define OAME_FIDX_HI   4
`define OAME_FIDX_LO   0
`define OAME_LIT_HI    7
`define OAME_LIT_LO    0

// Opcode patterns
`define OAME_PAT_IOR_LIT   4'hD
`define OAME_PAT_IOR_FILE  6'h04
`define OAME_PAT_COPY      6'h08

// Destination select
`define OAME_DEST_ACC  1'b0

// Reset values
`define OAME_ACC_RST   8'h00
`define OAME_ZERO_RST  1'b0
`define OAME_FILE_RST  8'h00
`define OAME_IDX_RST   5'h00
`define OAME_BYTE_ZERO 8'h00

// File space size
`define OAME_FILE_DEPTH 32

`endif

// [core/oame_pkg.sv]
// Types shared by the exec datapath modules
package oame_pkg;

  typedef logic [7:0]  oame_byte_t;
  typedef logic [4:0]  oame_idx_t;
  typedef logic [11:0] oame_word_t;

  typedef enum {
    OAME_K_NONE,
    OAME_K_IOR_LIT,
    OAME_K_IOR_FILE,
    OAME_K_COPY
  } oame_op_t;

endpackage

// [core/oame_file_regs.sv]
// Thirty-two entry file register space with two read ports
`timescale 1ns/1ps
`include "oame_params.svh"

module oame_file_regs
  import oame_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Write port
  input  wire logic       wr_en,
  input  oame_idx_t       wr_idx,
  input  oame_byte_t      wr_data,
  // Operand read port
  input  oame_idx_t       rd_idx_a,
  output oame_byte_t      rd_data_a,
  // Observation read port
  input  oame_idx_t       rd_idx_b,
  output oame_byte_t      rd_data_b
);

  oame_byte_t mem_q [`OAME_FILE_DEPTH];
  oame_byte_t mem_d [`OAME_FILE_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Next contents
  always_comb begin
    for (int i = 0; i < `OAME_FILE_DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en) begin
      mem_d[wr_idx] = wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  always_ff @(posedge clk) begin
    for (int i = 0; i < `OAME_FILE_DEPTH; i++) begin
      if (rst) begin
        mem_q[i] <= `OAME_FILE_RST;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reads
  assign rd_data_a = mem_q[rd_idx_a];
  assign rd_data_b = mem_q[rd_idx_b];

endmodule

// [core/oame_exec.sv]
// Execution datapath for the OR and copy instructions of the core
//
// How it works
// - Opcode 1101 kkkk kkkk ORs the accumulator with the 8-bit literal.
// - The literal OR writes the accumulator and leaves file regs alone.
// - Opcode 0001 00df ffff ORs the accumulator with file register f.
// - The register OR goes to the accumulator if d is 0, to f if d is 1.
// - Opcode 0010 00df ffff copies f to the accumulator or back to f.
// - The copy sets the zero flag from the value, so d=1 tests f.
`timescale 1ns/1ps
`include "oame_params.svh"

module oame_exec
  import oame_pkg::*;
(
  // Clock and reset
  input  wire logic  REF_CLK,
  input  wire logic  RESET,
  // Instruction from decode
  input  wire logic  INSTR_VALID,
  input  oame_word_t INSTR_WORD,
  // Accumulator preload
  input  wire logic  ACC_LOAD,
  input  oame_byte_t ACC_LOAD_DATA,
  // File register preload
  input  wire logic  FILE_LOAD,
  input  oame_idx_t  FILE_LOAD_IDX,
  input  oame_byte_t FILE_LOAD_DATA,
  // File register observation
  input  oame_idx_t  PEEK_IDX,
  output oame_byte_t PEEK_DATA,
  // Accumulator and status
  output oame_byte_t ACC_VALUE,
  output logic       ZERO_FLAG,
  // Execution report
  output logic       EXEC_DONE,
  output logic       EXEC_UNKNOWN,
  output logic       WB_FILE,
  output oame_idx_t  WB_IDX,
  output oame_byte_t WB_DATA
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Classify an instruction word
  function automatic oame_op_t decode_op(input oame_word_t w);
    oame_op_t op;
    op = OAME_K_NONE;
    if (w[`OAME_OPC4_HI:`OAME_OPC4_LO] == `OAME_PAT_IOR_LIT) begin
      op = OAME_K_IOR_LIT;
    end else if (w[`OAME_OPC4_HI:`OAME_OPC6_LO] == `OAME_PAT_IOR_FILE) begin
      op = OAME_K_IOR_FILE;
    end else if (w[`OAME_OPC4_HI:`OAME_OPC6_LO] == `OAME_PAT_COPY) begin
      op = OAME_K_COPY;
    end
    return op;
  endfunction

  // Zero test of an 8-bit result
  function automatic logic is_zero(input oame_byte_t v);
    return (v == `OAME_BYTE_ZERO);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  oame_op_t   op;
  oame_idx_t  fidx;
  oame_byte_t lit;
  logic       dest_file;
  oame_byte_t file_operand;
  oame_byte_t peek_value;

  assign op        = INSTR_VALID ? decode_op(INSTR_WORD) : OAME_K_NONE;
  assign fidx      = INSTR_WORD[`OAME_FIDX_HI:`OAME_FIDX_LO];
  assign lit       = INSTR_WORD[`OAME_LIT_HI:`OAME_LIT_LO];
  assign dest_file = (INSTR_WORD[`OAME_DEST_BIT] != `OAME_DEST_ACC);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  oame_byte_t acc_q;
  oame_byte_t acc_d;
  logic       zero_q;
  logic       zero_d;
  logic       done_q;
  logic       done_d;
  logic       unk_q;
  logic       unk_d;
  logic       wbf_q;
  logic       wbf_d;
  oame_idx_t  wbi_q;
  oame_idx_t  wbi_d;
  oame_byte_t wbd_q;
  oame_byte_t wbd_d;
  oame_byte_t peek_q;
  oame_byte_t peek_d;

  // File write port controls
  logic       fwr_en;
  oame_idx_t  fwr_idx;
  oame_byte_t fwr_data;

  oame_byte_t result;

  ////////////////////////////////////////////////////////////////////////////
  // Execute
  always_comb begin
    result   = `OAME_BYTE_ZERO;
    acc_d    = acc_q;
    zero_d   = zero_q;
    done_d   = 1'b0;
    unk_d    = 1'b0;
    wbf_d    = 1'b0;
    wbi_d    = wbi_q;
    wbd_d    = wbd_q;
    fwr_en   = 1'b0;
    fwr_idx  = FILE_LOAD_IDX;
    fwr_data = FILE_LOAD_DATA;
    peek_d   = peek_value;

    unique case (op)
      OAME_K_IOR_LIT: begin
        result = acc_q | lit;
        acc_d  = result;
        zero_d = is_zero(result);
        done_d = 1'b1;
      end
      OAME_K_IOR_FILE: begin
        result = acc_q | file_operand;
        zero_d = is_zero(result);
        done_d = 1'b1;
        if (dest_file) begin
          fwr_en   = 1'b1;
          fwr_idx  = fidx;
          fwr_data = result;
          wbf_d    = 1'b1;
          wbi_d    = fidx;
          wbd_d    = result;
        end else begin
          acc_d = result;
        end
      end
      OAME_K_COPY: begin
        result = file_operand;
        zero_d = is_zero(result);
        done_d = 1'b1;
        if (dest_file) begin
          fwr_en   = 1'b1;
          fwr_idx  = fidx;
          fwr_data = result;
          wbf_d    = 1'b1;
          wbi_d    = fidx;
          wbd_d    = result;
        end else begin
          acc_d = result;
        end
      end
      OAME_K_NONE: begin
        // Preloads act only in cycles without an instruction
        if (INSTR_VALID) begin
          unk_d = 1'b1;
        end else begin
          if (ACC_LOAD) begin
            acc_d = ACC_LOAD_DATA;
          end
          if (FILE_LOAD) begin
            fwr_en = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register space
  oame_file_regs u_file_regs (
    .clk       (REF_CLK),
    .rst       (RESET),
    .wr_en     (fwr_en),
    .wr_idx    (fwr_idx),
    .wr_data   (fwr_data),
    .rd_idx_a  (fidx),
    .rd_data_a (file_operand),
    .rd_idx_b  (PEEK_IDX),
    .rd_data_b (peek_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State registers, one instruction per clock
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      acc_q  <= `OAME_ACC_RST;
      zero_q <= `OAME_ZERO_RST;
      done_q <= 1'b0;
      unk_q  <= 1'b0;
      wbf_q  <= 1'b0;
      wbi_q  <= `OAME_IDX_RST;
      wbd_q  <= `OAME_BYTE_ZERO;
      peek_q <= `OAME_BYTE_ZERO;
    end else begin
      acc_q  <= acc_d;
      zero_q <= zero_d;
      done_q <= done_d;
      unk_q  <= unk_d;
      wbf_q  <= wbf_d;
      wbi_q  <= wbi_d;
      wbd_q  <= wbd_d;
      peek_q <= peek_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign ACC_VALUE    = acc_q;
  assign ZERO_FLAG    = zero_q;
  assign EXEC_DONE    = done_q;
  assign EXEC_UNKNOWN = unk_q;
  assign WB_FILE      = wbf_q;
  assign WB_IDX       = wbi_q;
  assign WB_DATA      = wbd_q;
  assign PEEK_DATA    = peek_q;

endmodule

// [tb/oame_chk_assertions.sv]
// Port checks for the exec datapath
`timescale 1ns/1ps
module oame_chk
  import oame_pkg::*;
(
  // Clock and reset
  input wire logic  REF_CLK,
  input wire logic  RESET,
  // Instruction
  input wire logic  INSTR_VALID,
  input oame_word_t INSTR_WORD,
  // Results
  input oame_byte_t ACC_VALUE,
  input wire logic  ZERO_FLAG,
  input wire logic  EXEC_DONE,
  input wire logic  WB_FILE,
  input oame_idx_t  WB_IDX,
  input oame_byte_t WB_DATA
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  logic       lit, rog, cpy, d;
  oame_byte_t k;
  oame_idx_t  fx;
  assign lit = INSTR_VALID && INSTR_WORD[11:8] == 4'hD;
  assign rog = INSTR_VALID && INSTR_WORD[11:6] == 6'h04;
  assign cpy = INSTR_VALID && INSTR_WORD[11:6] == 6'h08;
  assign d   = INSTR_WORD[5];
  assign k   = INSTR_WORD[7:0];
  assign fx  = INSTR_WORD[4:0];
  ////////////////////////////////////////
  lit_or_acc_a:
  assert property (lit |=> EXEC_DONE &&
    ACC_VALUE == ($past(ACC_VALUE) | $past(k))) else $error("lit or");
  lit_no_wb_a:
  assert property (lit |=> !WB_FILE && $stable(WB_IDX))
    else $error("lit wrote file");
  reg_or_done_a:
  assert property (rog |=> EXEC_DONE &&
    (ACC_VALUE | $past(ACC_VALUE)) == ACC_VALUE) else $error("reg or");
  or_to_file_a:
  assert property (rog && d |=> WB_FILE && WB_IDX == $past(fx) &&
    $stable(ACC_VALUE) && (WB_DATA | $past(ACC_VALUE)) == WB_DATA)
    else $error("or to file");
  or_to_acc_a:
  assert property (rog && !d |=> !WB_FILE) else $error("or to acc");
  copy_dest_a:
  assert property (cpy |=> EXEC_DONE && WB_FILE == $past(d))
    else $error("copy dest");
  copy_test_a:
  assert property (cpy && d |=> $stable(ACC_VALUE) &&
    WB_IDX == $past(fx) && ZERO_FLAG == (WB_DATA == 8'h00))
    else $error("copy test");
  zero_acc_a:
  assert property (EXEC_DONE && !WB_FILE |->
    ZERO_FLAG == (ACC_VALUE == 8'h00)) else $error("zero flag");
endmodule
bind oame_exec oame_chk chk_u (.REF_CLK, .RESET, .INSTR_VALID,
  .INSTR_WORD, .ACC_VALUE, .ZERO_FLAG, .EXEC_DONE, .WB_FILE, .WB_IDX,
  .WB_DATA);

// [tb/oame_issue_model.sv]
// Instruction issue model facing the exec datapath
`timescale 1ns/1ps
module oame_issue_model
  import oame_pkg::*;
(
  // Instruction out
  output logic       valid,
  output oame_word_t word
);
  initial begin
    valid = 1'b0;
    word  = 12'h000;
  end
  // Idle word changes every cycle
  task automatic drive(input logic v, input oame_word_t w);
    valid <= v;
    word  <= v ? w : ~word;
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the exec datapath
`timescale 1ns/1ps
module tb_top;
  import oame_pkg::*;
  typedef struct packed {
    logic unk, wb, z;
    oame_idx_t wbi;
    oame_byte_t acc, wbd;
  } oame_exp_t;
  logic       clk, rst, vld, al, fl, z, done, unk, wb, rz;
  oame_word_t wrd;
  oame_byte_t ad, fd, peek, acc, wbd, ra;
  oame_idx_t  fi, pi, wbi;
  oame_byte_t rf [32];
  oame_exp_t  q [$];
  oame_word_t dir_w [6] = '{12'hD35, 12'h227, 12'h207, 12'hD00, 12'h000,
                            12'h13F};
  int         miscompares, num_checks;
  int         seed = 32'hEAA20D74;
  ////////////////////////////////////////
  oame_exec dut_u (.REF_CLK(clk), .RESET(rst), .INSTR_VALID(vld),
    .INSTR_WORD(wrd), .ACC_LOAD(al), .ACC_LOAD_DATA(ad), .FILE_LOAD(fl),
    .FILE_LOAD_IDX(fi), .FILE_LOAD_DATA(fd), .PEEK_IDX(pi),
    .PEEK_DATA(peek), .ACC_VALUE(acc), .ZERO_FLAG(z), .EXEC_DONE(done),
    .EXEC_UNKNOWN(unk), .WB_FILE(wb), .WB_IDX(wbi), .WB_DATA(wbd));
  oame_issue_model dec_u (.valid(vld), .word(wrd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic step(input logic v, input oame_word_t w, input logic a,
                      input logic f, input oame_idx_t i, input oame_byte_t x);
    @(negedge clk);
    dec_u.drive(v, w);
    al <= a;
    fl <= f;
    fi <= i;
    ad <= x;
    fd <= x;
  endtask
  task automatic exec(input oame_word_t w);
    oame_exp_t e;
    oame_byte_t r;
    e = '0;
    r = rf[w[4:0]];
    if (w[11:8] == 4'hD) r = ra | w[7:0];
    else if (w[11:6] == 6'h04) r = ra | r;
    else if (w[11:6] != 6'h08) e.unk = 1'b1;
    if (!e.unk) begin
      rz = (r == 8'h00);
      e.wb = w[11:8] != 4'hD && w[5];
      if (e.wb) rf[w[4:0]] = r;
      else ra = r;
      e.wbd = r;
      e.wbi = w[4:0];
    end
    e.z = rz;
    e.acc = ra;
    q.push_back(e);
    step(1'b1, w, 1'b0, 1'b0, 5'h00, 8'h00);
  endtask
  // Result monitor
  always @(posedge clk) begin
    oame_exp_t e;
    #1;
    if (done === 1'b1 || unk === 1'b1) begin
      cmp({7'h00, q.size() > 0}, 8'h01);
      e = q.pop_front();
      cmp({7'h00, unk}, {7'h00, e.unk});
      cmp({7'h00, done}, {7'h00, !e.unk});
      cmp({7'h00, wb}, {7'h00, e.wb});
      cmp({7'h00, z}, {7'h00, e.z});
      cmp(acc, e.acc);
      if (e.wb) cmp(wbd, e.wbd);
      if (e.wb) cmp({3'h0, wbi}, {3'h0, e.wbi});
    end
  end
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
  initial begin
    {rst, al, ad, fl, fi, fd, pi, rz, ra} = {1'b1, 37'h0};
    repeat (16) @(negedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      rf[i] = (i == 7) ? 8'h00 : 8'($random(seed));
      step(1'b0, 12'h000, 1'b0, 1'b1, 5'(i), rf[i]);
    end
    ra = 8'h9A;
    step(1'b0, 12'h000, 1'b1, 1'b0, 5'h00, ra);
    foreach (dir_w[j])
      exec(dir_w[j]);
    for (int n = 0; n < 300; n++) begin
      int r;
      r = $random(seed);
      case (r[13:12])
        2'h0: exec({4'hD, r[7:0]});
        2'h1: exec({6'h04, r[5:0]});
        2'h2: exec({6'h08, r[5:0]});
        default: exec(r[11:0]);
      endcase
    end
    for (int i = 0; i <= 32; i++) begin
      step(1'b0, 12'h000, 1'b0, 1'b0, 5'h00, 8'h00);
      if (i > 0) cmp(peek, rf[i - 1]);
      pi <= 5'(i);
    end
    cmp({7'h00, q.size() == 0}, 8'h01);
    end_sim();
  end
endmodule
